// ===== shared/asc_pkg.sv
/*
  Package for the ADC sequence control block: register indices and byte
  addresses, field positions, reset values, channel codes, timing constants.
  Assumes an APB slave with 32-bit data, one register per aligned word.
*/
`default_nettype none

package asc_pkg;

  // ----------------------------------------------------------------------
  // Register map: printed offsets are indices, byte address is index * 4
  // ----------------------------------------------------------------------
  localparam logic [9:0] IDX_SEQ_CONFIG = 10'h0B5;
  localparam logic [9:0] IDX_CONTROL = 10'h0B0;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h0B1;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h0B2;
  localparam logic [9:0] IDX_RESULT = 10'h0B3;
  localparam logic [11:0] ADDR_SEQ_CONFIG = {IDX_SEQ_CONFIG, 2'h0};
  localparam logic [11:0] ADDR_CONTROL = {IDX_CONTROL, 2'h0};
  localparam logic [11:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'h0};
  localparam logic [11:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'h0};
  localparam logic [11:0] ADDR_RESULT = {IDX_RESULT, 2'h0};

  // ----------------------------------------------------------------------
  // Fields and reset values of the configuration, control, interrupt and result registers
  // ----------------------------------------------------------------------
  localparam int REF_LSB = 6;
  localparam int DECIM_LSB = 4;
  localparam int END_LSB = 0;
  localparam logic [7:0] SEQ_CONFIG_RESET = 8'h10;
  localparam int CTRL_START_BIT = 0;
  localparam int IRQ_SEQ_DONE_BIT = 0;
  localparam int IRQ_OVERRUN_BIT = 1;
  localparam int RESULT_VALID_BIT = 16;
  localparam logic [1:0] IRQ_RESET = 2'h0;

  // ----------------------------------------------------------------------
  // Channel codes
  // ----------------------------------------------------------------------
  localparam logic [3:0] CH_FIRST_SINGLE = 4'h0;
  localparam logic [3:0] CH_LAST_SINGLE = 4'h7;
  localparam logic [3:0] CH_FIRST_DIFF = 4'h8;
  localparam logic [3:0] CH_LAST_DIFF = 4'hB;
  localparam logic [3:0] CH_GROUND = 4'hC;
  localparam logic [3:0] CH_POS_REF = 4'hD;
  localparam logic [3:0] CH_TEMP = 4'hE;
  localparam logic [3:0] CH_SUPPLY_DIV3 = 4'hF;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int SYS_CLK_HZ = 20_000_000;
  localparam int CONV_CLK_HZ = 4_000_000;
  localparam int CONV_DIV = SYS_CLK_HZ / CONV_CLK_HZ;
  localparam logic [2:0] CONV_DIV_LAST = 3'(CONV_DIV - 1);
  localparam logic [9:0] SETTLE_TICKS = 10'h010;
  localparam logic [9:0] DECIM_64 = 10'h040;
  localparam logic [9:0] DECIM_128 = 10'h080;
  localparam logic [9:0] DECIM_256 = 10'h100;
  localparam logic [9:0] DECIM_512 = 10'h200;

  typedef enum logic [2:0] {
    ASC_IDLE = 3'b001,
    ASC_SETTLE = 3'b010,
    ASC_DECIM = 3'b100
  } asc_state_t;

endpackage : asc_pkg

`default_nettype wire

// ===== rtl/asc_tick_div.sv
/*
  Divides the system clock down to the conversion clock as a one-cycle
  tick. Assumes a single clock domain and a synchronous clock enable.
*/
`timescale 1ns/10ps
`default_nettype none

module asc_tick_div (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  output logic tick_o
);

  logic [2:0] count;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count <= 3'h0;
    end else if (ce_i) begin
      count <= (count == asc_pkg::CONV_DIV_LAST) ? 3'h0 : count + 3'h1;
    end
  end

  assign tick_o = ce_i && (count == asc_pkg::CONV_DIV_LAST);

endmodule : asc_tick_div

`default_nettype wire

// ===== rtl/asc_conv_timer.sv
/*
  Down-counter of conversion clock ticks. Load sets the count; done pulses
  on the tick that takes the count from one to zero. Assumes load values
  are nonzero.
*/
`timescale 1ns/10ps
`default_nettype none

module asc_conv_timer (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic tick_i,
  input wire logic load_i,
  input wire logic [9:0] load_val_i,
  output logic done_o
);

  logic [9:0] count;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count <= 10'h000;
    end else if (ce_i) begin
      if (load_i) begin
        count <= load_val_i;
      end else if (tick_i && count != 10'h000) begin
        count <= count - 10'h001;
      end
    end
  end

  // Done must not look at load: the sequencer raises load from done
  assign done_o = ce_i && tick_i && (count == 10'h001);

endmodule : asc_conv_timer

`default_nettype wire

// ===== rtl/asc_seq_ctrl.sv
/*
  ADC sequence control: configuration register, channel sequencer,
  conversion timing, result capture, DMA triggers and a status interrupt.
  Assumes an APB master on the same clock and a modulator whose result
  is valid on RESULT_I when the conversion ends.
*/
// Implementation choice: the APB slave port.
`timescale 1ns/10ps
`default_nettype none

module asc_seq_ctrl (
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic CE_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic [13:0] RESULT_I,
  output logic [1:0] REF_SEL_O,
  output logic [1:0] DECIM_SEL_O,
  output logic [3:0] MUX_SEL_O,
  output logic SETTLE_O,
  output logic CONVERT_O,
  output logic [7:0] DMA_CH_O,
  output logic DMA_ALL_O,
  output logic IRQ_O
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [9:0] decim_ticks(input logic [1:0] sel);
    unique case (sel)
      2'h0: decim_ticks = asc_pkg::DECIM_64;
      2'h1: decim_ticks = asc_pkg::DECIM_128;
      2'h2: decim_ticks = asc_pkg::DECIM_256;
      2'h3: decim_ticks = asc_pkg::DECIM_512;
    endcase
  endfunction : decim_ticks

  function automatic logic [3:0] first_channel(input logic [3:0] last);
    if (last <= asc_pkg::CH_LAST_SINGLE) begin
      first_channel = asc_pkg::CH_FIRST_SINGLE;
    end else if (last <= asc_pkg::CH_LAST_DIFF) begin
      first_channel = asc_pkg::CH_FIRST_DIFF;
    end else begin
      first_channel = last;
    end
  endfunction : first_channel

  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] reg_addr);
    addr_is = (a == reg_addr);
  endfunction : addr_is

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [7:0] seq_config;
  logic [3:0] result_chan;
  logic [13:0] result;
  logic result_unread;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic [3:0] cur_chan;
  logic [3:0] seq_end;
  asc_pkg::asc_state_t state;
  asc_pkg::asc_state_t next_state;
  logic tick;
  logic timer_load;
  logic [9:0] timer_val;
  logic timer_done;
  logic conv_done;
  logic seq_last;
  logic start_req;
  logic wr_en;
  logic rd_en;
  logic addr_ok;

  // ----------------------------------------------------------------------
  // APB slave: zero wait states, read data registered in setup phase
  // ----------------------------------------------------------------------
  assign addr_ok = addr_is(PADDR_I, asc_pkg::ADDR_SEQ_CONFIG) ||
                   addr_is(PADDR_I, asc_pkg::ADDR_CONTROL) ||
                   addr_is(PADDR_I, asc_pkg::ADDR_IRQ_STATUS) ||
                   addr_is(PADDR_I, asc_pkg::ADDR_IRQ_MASK) ||
                   addr_is(PADDR_I, asc_pkg::ADDR_RESULT);
  assign PREADY_O = PSEL_I && PENABLE_I;
  assign PSLVERR_O = PSEL_I && PENABLE_I && !addr_ok;
  assign wr_en = CE_I && PSEL_I && PENABLE_I && PWRITE_I && addr_ok;
  assign rd_en = CE_I && PSEL_I && PENABLE_I && !PWRITE_I && addr_ok;

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      PRDATA_O <= 32'h0000_0000;
    end else if (CE_I && PSEL_I && !PENABLE_I) begin
      PRDATA_O <= 32'h0000_0000;
      if (addr_is(PADDR_I, asc_pkg::ADDR_SEQ_CONFIG)) begin
        PRDATA_O[7:0] <= {seq_config[7:4], result_chan};
      end else if (addr_is(PADDR_I, asc_pkg::ADDR_CONTROL)) begin
        PRDATA_O[asc_pkg::CTRL_START_BIT] <= (state != asc_pkg::ASC_IDLE);
      end else if (addr_is(PADDR_I, asc_pkg::ADDR_IRQ_STATUS)) begin
        PRDATA_O[1:0] <= irq_status;
      end else if (addr_is(PADDR_I, asc_pkg::ADDR_IRQ_MASK)) begin
        PRDATA_O[1:0] <= irq_mask;
      end else if (addr_is(PADDR_I, asc_pkg::ADDR_RESULT)) begin
        PRDATA_O[13:0] <= result;
        PRDATA_O[asc_pkg::RESULT_VALID_BIT] <= result_unread;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Configuration register
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      seq_config <= asc_pkg::SEQ_CONFIG_RESET;
    end else if (wr_en && addr_is(PADDR_I, asc_pkg::ADDR_SEQ_CONFIG)) begin
      seq_config <= PWDATA_I[7:0];
    end
  end

  assign REF_SEL_O = seq_config[asc_pkg::REF_LSB +: 2];
  assign DECIM_SEL_O = seq_config[asc_pkg::DECIM_LSB +: 2];
  assign start_req = wr_en && addr_is(PADDR_I, asc_pkg::ADDR_CONTROL) &&
                     PWDATA_I[asc_pkg::CTRL_START_BIT];

  // ----------------------------------------------------------------------
  // Conversion clock and timer
  // ----------------------------------------------------------------------
  asc_tick_div u_tick (
    .clk_i(CLK_I),
    .nrst_i(NRST_I),
    .ce_i(CE_I),
    .tick_o(tick)
  );

  asc_conv_timer u_timer (
    .clk_i(CLK_I),
    .nrst_i(NRST_I),
    .ce_i(CE_I),
    .tick_i(tick),
    .load_i(timer_load),
    .load_val_i(timer_val),
    .done_o(timer_done)
  );

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  assign conv_done = (state == asc_pkg::ASC_DECIM) && timer_done;
  assign seq_last = (cur_chan == seq_end);

  always_comb begin
    next_state = state;
    timer_load = 1'b0;
    timer_val = asc_pkg::SETTLE_TICKS;
    unique case (state)
      asc_pkg::ASC_IDLE: begin
        if (start_req) begin
          next_state = asc_pkg::ASC_SETTLE;
          timer_load = 1'b1;
        end
      end
      asc_pkg::ASC_SETTLE: begin
        // Settling runs for every rate, then the filter period follows
        if (timer_done) begin
          next_state = asc_pkg::ASC_DECIM;
          timer_load = 1'b1;
          timer_val = decim_ticks(DECIM_SEL_O);
        end
      end
      asc_pkg::ASC_DECIM: begin
        if (timer_done) begin
          timer_load = !seq_last;
          next_state = seq_last ? asc_pkg::ASC_IDLE : asc_pkg::ASC_SETTLE;
        end
      end
    endcase
    timer_load = timer_load && CE_I;
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      state <= asc_pkg::ASC_IDLE;
    end else if (CE_I) begin
      state <= next_state;
    end
  end

  // End channel is frozen at start so a mid-run write cannot strand the walk
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      cur_chan <= 4'h0;
      seq_end <= 4'h0;
    end else if (CE_I) begin
      if (state == asc_pkg::ASC_IDLE && start_req) begin
        seq_end <= seq_config[asc_pkg::END_LSB +: 4];
        cur_chan <= first_channel(seq_config[asc_pkg::END_LSB +: 4]);
      end else if (conv_done && !seq_last) begin
        cur_chan <= cur_chan + 4'h1;
      end
    end
  end

  // Channel code goes to the multiplexer as is: pairs and internal sources
  // are decoded by the analog side
  assign MUX_SEL_O = cur_chan;
  assign SETTLE_O = (state == asc_pkg::ASC_SETTLE);
  assign CONVERT_O = (state == asc_pkg::ASC_DECIM);

  // ----------------------------------------------------------------------
  // Result capture and DMA triggers
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      result <= 14'h0000;
      result_chan <= 4'h0;
    end else if (CE_I && conv_done) begin
      result <= RESULT_I;
      result_chan <= cur_chan;
    end
  end

  // A new result wins over a read that clears the flag in the same cycle
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      result_unread <= 1'b0;
    end else if (CE_I) begin
      if (conv_done) begin
        result_unread <= 1'b1;
      end else if (rd_en && addr_is(PADDR_I, asc_pkg::ADDR_RESULT)) begin
        result_unread <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      DMA_CH_O <= 8'h00;
      DMA_ALL_O <= 1'b0;
    end else if (CE_I) begin
      DMA_ALL_O <= conv_done;
      DMA_CH_O <= 8'h00;
      if (conv_done && cur_chan <= asc_pkg::CH_LAST_SINGLE) begin
        DMA_CH_O[cur_chan[2:0]] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Status interrupt: sequence end and overrun only, never per conversion
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      irq_status <= asc_pkg::IRQ_RESET;
    end else if (CE_I) begin
      if (rd_en && addr_is(PADDR_I, asc_pkg::ADDR_IRQ_STATUS)) begin
        // Clear only what the read returned, so an event at the setup edge survives
        irq_status <= irq_status & ~PRDATA_O[1:0];
      end
      if (conv_done && seq_last) begin
        irq_status[asc_pkg::IRQ_SEQ_DONE_BIT] <= 1'b1;
      end
      if (conv_done && result_unread) begin
        irq_status[asc_pkg::IRQ_OVERRUN_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      irq_mask <= asc_pkg::IRQ_RESET;
    end else if (wr_en && addr_is(PADDR_I, asc_pkg::ADDR_IRQ_MASK)) begin
      irq_mask <= PWDATA_I[1:0];
    end
  end

  assign IRQ_O = |(irq_status & irq_mask);

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  logic [13:0] conv_cycles;
  logic [9:0] decim_count;

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      conv_cycles <= 14'h0000;
      decim_count <= 10'h000;
    end else if (CE_I) begin
      conv_cycles <= (state == asc_pkg::ASC_IDLE || conv_done) ? 14'h0000 :
                     conv_cycles + 14'h0001;
      decim_count <= (state != asc_pkg::ASC_DECIM || conv_done) ? 10'h000 :
                     decim_count + 10'(tick);
    end
  end

  a_ref_follows: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    wr_en && addr_is(PADDR_I, asc_pkg::ADDR_SEQ_CONFIG) |=> REF_SEL_O == $past(PWDATA_I[7:6]))
    else $error("reference select does not follow write");

  a_decim_ticks: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    conv_done |-> decim_count + 10'h001 == decim_ticks(DECIM_SEL_O))
    else $error("filter period differs from decimation rate");

  a_conv_time: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    conv_done && CE_I |-> (conv_cycles + 14'h0001 <=
      14'(({4'h0, decim_ticks(DECIM_SEL_O)} + 14'h0010) * 14'h0005)) &&
      (conv_cycles + 14'h0001 >
      14'(({4'h0, decim_ticks(DECIM_SEL_O)} + 14'h000F) * 14'h0005)))
    else $error("conversion length wrong");

  a_single_start: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    start_req && state == asc_pkg::ASC_IDLE && seq_config[3:0] <= 4'h7 |=> cur_chan == 4'h0)
    else $error("single-ended sequence not from input 0");

  a_diff_start: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    start_req && state == asc_pkg::ASC_IDLE && seq_config[3:0] >= 4'h8 &&
    seq_config[3:0] <= 4'hB |=> cur_chan == 4'h8)
    else $error("differential sequence not from first pair");

  a_single_conv: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    start_req && state == asc_pkg::ASC_IDLE && seq_config[3:0] > 4'hB
    |=> cur_chan == seq_end && cur_chan == $past(seq_config[3:0]))
    else $error("single conversion source wrong");

  a_step_up: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    conv_done && !seq_last |=> cur_chan == $past(cur_chan) + 4'h1 && SETTLE_O)
    else $error("sequence did not step to next channel");

  a_seq_stop: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    conv_done && seq_last |=> state == asc_pkg::ASC_IDLE)
    else $error("sequence ran past end channel");

  a_read_chan: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    conv_done ##1 (PSEL_I && !PENABLE_I && addr_is(PADDR_I, asc_pkg::ADDR_SEQ_CONFIG) &&
    !conv_done) |=> PRDATA_O[3:0] == $past(cur_chan, 2))
    else $error("channel readback is not the result channel");

  a_dma_pulse: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    conv_done && CE_I && cur_chan <= 4'h7 |=> DMA_ALL_O && DMA_CH_O == 8'h01 << $past(cur_chan))
    else $error("DMA trigger missing");

  a_no_conv_irq: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    conv_done && !seq_last && !result_unread && irq_status == 2'h0 |=> irq_status == 2'h0)
    else $error("interrupt raised by sequence conversion");

endmodule : asc_seq_ctrl

`default_nettype wire

// ===== verification/asc_mod_model.sv
/*
  Behavioural model of the analog multiplexer and modulator facing the
  sequence controller. Assumes the controller samples RESULT_I on the
  cycle that ends a conversion, while SETTLE_O or CONVERT_O is high.
*/
`timescale 1ns/10ps
`default_nettype none

module asc_mod_model (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [3:0] mux_sel_i,
  input wire logic settle_i,
  input wire logic convert_i,
  output logic [13:0] result_o
);
  // ----------------------------------------------------------------------
  // Result word
  // ----------------------------------------------------------------------
  logic [13:0] idle_pat;

  // Outside a conversion the output churns, so a stale sample shows up
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      idle_pat <= 14'h0000;
    end else begin
      idle_pat <= idle_pat + 14'h1357;
    end
  end

  // The channel code rides in the top bits so the bench can trace origin
  assign result_o = (settle_i || convert_i) ? {mux_sel_i, 10'h2A5} : idle_pat;
endmodule : asc_mod_model

`default_nettype wire

// ===== verification/adc_sequence_control_bench.sv
/*
  Self-checking bench for the ADC sequence controller: APB master tasks,
  modulator model, one task per scenario. Assumes zero-wait APB and the
  conversion clock derived from a 20 MHz system clock.
*/
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin miscompares++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, ex, gt); end end

module adc_sequence_control_bench;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic clk, nrst, ce, psel, penable, pwrite, pready, pslverr, settle, convert, dma_all, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [13:0] result;
  logic [1:0] ref_sel, decim_sel;
  logic [3:0] mux_sel;
  logic [7:0] dma_ch;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  int dma_pulses = 0;

  asc_seq_ctrl DUT (.CLK_I(clk), .NRST_I(nrst), .CE_I(ce), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .RESULT_I(result),
    .REF_SEL_O(ref_sel), .DECIM_SEL_O(decim_sel), .MUX_SEL_O(mux_sel),
    .SETTLE_O(settle), .CONVERT_O(convert), .DMA_CH_O(dma_ch), .DMA_ALL_O(dma_all),
    .IRQ_O(irq));

  asc_mod_model MODEL (.clk_i(clk), .nrst_i(nrst), .mux_sel_i(mux_sel),
    .settle_i(settle), .convert_i(convert), .result_o(result));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (dma_all === 1'b1) dma_pulses++;
    if (cycles == 40000) begin
      miscompares++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int w;
    w = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && w < 50) begin
      @(posedge clk);
      w++;
    end
    if (w == 50) miscompares++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] ex);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    `CHK(nm, ex, r)
  endtask : rd_chk

  task end_sim;
    if (miscompares == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic reset_values;
    logic [31:0] r;
    logic e;
    rd_chk("config reset", asc_pkg::ADDR_SEQ_CONFIG, 32'h00000010);
    `CHK("ref reset", 2'h0, ref_sel)
    `CHK("decim reset", 2'h1, decim_sel)
    apb(1'b0, 12'h000, 32'h0, r, e);
    `CHK("unmapped err", 1'b1, e)
    `CHK("unmapped data", 32'h00000000, r)
  endtask : reset_values

  // A write while the clock enable is low must leave the register alone
  task automatic gated_write;
    @(posedge clk);
    ce <= 1'b0;
    wr(asc_pkg::ADDR_SEQ_CONFIG, 32'h000000E5);
    @(posedge clk);
    ce <= 1'b1;
    rd_chk("gated config", asc_pkg::ADDR_SEQ_CONFIG, 32'h00000010);
  endtask : gated_write

  task automatic run_seq(input logic [1:0] rf, input logic [1:0] dv,
                         input logic [3:0] last_ch, input logic msk);
    int rate, first, n, cnt, d0;
    rate = 64 << dv;
    first = (last_ch <= 4'h7) ? 0 : ((last_ch <= 4'hB) ? 8 : int'(last_ch));
    n = int'(last_ch) - first + 1;
    wr(asc_pkg::ADDR_IRQ_MASK, {31'h0, msk});
    wr(asc_pkg::ADDR_SEQ_CONFIG, {24'h0, rf, dv, last_ch});
    @(posedge clk);
    `CHK("ref out", rf, ref_sel)
    `CHK("decim out", dv, decim_sel)
    d0 = dma_pulses;
    wr(asc_pkg::ADDR_CONTROL, 32'h00000001);
    for (int c = first; c <= int'(last_ch); c++) begin
      cnt = 0;
      while (dma_all !== 1'b1 && cnt < 3000) begin
        @(posedge clk);
        cnt++;
        if (cnt == 3) begin
          `CHK("channel", 4'(c), mux_sel)
          `CHK("settling", 1'b1, settle)
          `CHK("irq in run", 1'b0, irq)
        end
        if (cnt == rate * 5 + 40) begin
          `CHK("converting", 1'b1, convert)
          `CHK("settle over", 1'b0, settle)
        end
      end
      `CHK("conv time", 1'b1, cnt > (rate + 15) * 5 && cnt <= (rate + 16) * 5 + 2)
      `CHK("dma ch", (c <= 7) ? (8'h01 << c) : 8'h00, dma_ch)
      @(posedge clk);
      `CHK("dma pulse", 1'b0, dma_all)
    end
    repeat (3) @(posedge clk);
    rd_chk("busy", asc_pkg::ADDR_CONTROL, 32'h00000000);
    `CHK("irq done", msk, irq)
    rd_chk("status", asc_pkg::ADDR_IRQ_STATUS, (n > 1) ? 32'h3 : 32'h1);
    @(posedge clk);
    `CHK("irq cleared", 1'b0, irq)
    rd_chk("status clr", asc_pkg::ADDR_IRQ_STATUS, 32'h00000000);
    rd_chk("readback", asc_pkg::ADDR_SEQ_CONFIG, {24'h0, rf, dv, last_ch});
    // A new end channel must not show: the field reads the result's channel
    wr(asc_pkg::ADDR_SEQ_CONFIG, {24'h0, rf, dv, ~last_ch});
    rd_chk("chan not end", asc_pkg::ADDR_SEQ_CONFIG, {24'h0, rf, dv, last_ch});
    rd_chk("result", asc_pkg::ADDR_RESULT, {15'h0, 1'b1, 2'h0, last_ch, 10'h2A5});
    `CHK("dma count", n, dma_pulses - d0)
  endtask : run_seq

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    reset_values();
    gated_write();
    run_seq(2'h1, 2'h0, 4'h2, 1'b1);
    run_seq(2'h3, 2'h0, 4'h9, 1'b1);
    for (int e = 12; e < 16; e++) begin
      run_seq(2'(e), 2'h0, 4'(e), 1'b1);
    end
    for (int d = 0; d < 4; d++) begin
      run_seq(2'h2, 2'(d), 4'h0, 1'(d));
    end
    end_sim();
  end
endmodule : adc_sequence_control_bench

`default_nettype wire
